/* File: design/ufa_defs.svh */
`ifndef UFA_DEFS_SVH
`define UFA_DEFS_SVH

// array geometry
`define UFA_ADDR_W 9
`define UFA_DATA_W 16
`define UFA_WORDS 512
`define UFA_SECTOR_BIT 8
`define UFA_ERASED 16'hffff
`define UFA_ADDR_RESET 9'h000
`define UFA_DATA_RESET 16'h0000

// oscillator: sys_clk cycles per oscillator tick, ticks per exported clock period
`define UFA_OSC_DIV 6
`define UFA_OSC_OUT_DIV 4

// operation lengths in oscillator ticks
`define UFA_PROG_TICKS 8
`define UFA_ERASE_TICKS 32
`define UFA_OP_CNT_W 16

// read-ahead buffer
`define UFA_FIFO_DEPTH 4

// positions in the synchronised pin vector
`define UFA_PINS 8
`define UFA_PIN_ASEL 0
`define UFA_PIN_ACLK 1
`define UFA_PIN_AIN 2
`define UFA_PIN_DSEL 3
`define UFA_PIN_DCLK 4
`define UFA_PIN_DIN 5
`define UFA_PIN_PROG 6
`define UFA_PIN_ERASE 7

`endif

/* File: design/ufa_pkg.sv */
package ufa_pkg;

    typedef enum logic [2:0] {
        UFA_IDLE = 3'b001,
        UFA_PROG = 3'b010,
        UFA_ERASE = 3'b100
    } ufa_state_t;

endpackage : ufa_pkg

/* File: design/ufa_fifo.sv */
`timescale 1ns/1ps
module ufa_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] slot [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    logic push;
    logic pop;
    logic [PW-1:0] next_wrPtr;
    logic [PW-1:0] next_rdPtr;

    assign inReady = count != (PW + 1)'(DEPTH);
    assign outValid = count != '0;
    assign outData = slot[rdPtr];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign next_wrPtr = (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
    assign next_rdPtr = (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) wrPtr <= next_wrPtr;
            if (pop) rdPtr <= next_rdPtr;
            if (push && !pop) count <= count + 1'b1;
            else if (pop && !push) count <= count - 1'b1;
        end
    end

    // storage needs no reset: a slot is only read after it was written
    always_ff @(posedge sys_clk) begin
        if (push) slot[wrPtr] <= inData;
    end

endmodule : ufa_fifo

/* File: design/ufa_flash_access.sv */
`timescale 1ns/1ps
`include "ufa_defs.svh"
// Functional notes
// - the array holds 512 words picked by a 9-bit address from 000h to 1FFh.
// - words 000h-0FFh form the first sector and 100h-1FFh the second.
// - each word is 16 bits wide; narrower widths are left to surrounding logic.
// - an erase clears one whole sector, so clearing the array takes two erases.
// - an internal oscillator times program and erase and is exported divided by four.
// - a program or erase request starts an internal operation that raises busy until done.
// - the array can also be programmed and read through the test access port.
// - both a single read and a stream read of consecutive words are supported.
// - an address clock pulse with shift select low steps the address by one unless busy or a fetch waits on a full read buffer.
// - a 9-bit address shift register and a 16-bit data shift register carry the serial lines.
module ufa_flash_access
    import ufa_pkg::*;
#(
    parameter int PROG_TICKS = `UFA_PROG_TICKS,
    parameter int ERASE_TICKS = `UFA_ERASE_TICKS,
    parameter int FIFO_DEPTH = `UFA_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic addrShiftSelect,
    input wire logic addrShiftClock,
    input wire logic addrSerialIn,
    input wire logic dataShiftSelect,
    input wire logic dataShiftClock,
    input wire logic dataSerialIn,
    input wire logic programReq,
    input wire logic eraseReq,
    input wire logic jtagWrite,
    input wire logic jtagRead,
    input wire logic [`UFA_ADDR_W-1:0] jtagAddr,
    input wire logic [`UFA_DATA_W-1:0] jtagWrData,
    output logic [`UFA_DATA_W-1:0] jtagRdData,
    output logic jtagRdValid,
    output logic dataSerialOut,
    output logic busy,
    output logic internalOscOut
);
    localparam int AW = `UFA_ADDR_W;
    localparam int DW = `UFA_DATA_W;
    localparam int NP = `UFA_PINS;
    localparam int CW = `UFA_OP_CNT_W;
    localparam int OSC_HALF = `UFA_OSC_DIV * `UFA_OSC_OUT_DIV / 2;

    function automatic logic sectorOf(input logic [AW-1:0] a);
        return a[`UFA_SECTOR_BIT];
    endfunction : sectorOf

    // ---- pin synchronisers: a level counts once stages two and three agree
    logic [NP-1:0] pinRaw;
    logic [NP-1:0] syncA;
    logic [NP-1:0] syncB;
    logic [NP-1:0] syncC;
    logic [NP-1:0] pinLevel;
    logic [NP-1:0] pinPrev;
    logic [NP-1:0] pinAgree;
    logic [NP-1:0] next_pinLevel;
    logic [NP-1:0] pinRise;

    assign pinRaw = {eraseReq, programReq, dataSerialIn, dataShiftClock,
                     dataShiftSelect, addrSerialIn, addrShiftClock, addrShiftSelect};
    assign pinAgree = ~(syncB ^ syncC);
    assign next_pinLevel = (syncC & pinAgree) | (pinLevel & ~pinAgree);
    assign pinRise = pinLevel & ~pinPrev;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
            pinLevel <= '0;
            pinPrev <= '0;
        end else begin
            syncA <= pinRaw;
            syncB <= syncA;
            syncC <= syncB;
            pinLevel <= next_pinLevel;
            pinPrev <= pinLevel;
        end
    end

    // ---- oscillator: tick enable, exported clock is tick rate divided by four
    logic [7:0] oscDiv;
    logic oscTick;
    logic oscPhase;

    assign oscTick = oscDiv == 8'(`UFA_OSC_DIV - 1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oscDiv <= 8'h00;
            oscPhase <= 1'b0;
            internalOscOut <= 1'b0;
        end else begin
            oscDiv <= oscTick ? 8'h00 : oscDiv + 8'h01;
            if (oscTick) oscPhase <= ~oscPhase;
            if (oscTick && oscPhase) internalOscOut <= ~internalOscOut;
        end
    end

    // ---- request decode
    ufa_state_t state;
    ufa_state_t next_state;
    logic idle;
    logic addrClkRise;
    logic dataClkRise;
    logic addrShift;
    logic addrStep;
    logic dataLoad;
    logic dataShift;
    logic pinProg;
    logic progStart;
    logic eraseStart;
    logic jtagRdTake;
    logic fetchPending;

    assign idle = state == UFA_IDLE;
    assign addrClkRise = pinRise[`UFA_PIN_ACLK];
    assign dataClkRise = pinRise[`UFA_PIN_DCLK];
    // every request below is gated by idle, so nothing starts while busy
    assign addrShift = idle & addrClkRise & pinLevel[`UFA_PIN_ASEL];
    assign addrStep = idle & addrClkRise & ~pinLevel[`UFA_PIN_ASEL] & ~fetchPending;
    assign dataLoad = idle & dataClkRise & ~pinLevel[`UFA_PIN_DSEL];
    assign dataShift = idle & dataClkRise & pinLevel[`UFA_PIN_DSEL];
    // edge detect: a program or erase pin still held from the last operation cannot restart it; a held jtagWrite can
    assign pinProg = pinRise[`UFA_PIN_PROG];
    assign progStart = idle & (pinProg | jtagWrite);
    assign eraseStart = idle & ~progStart & pinRise[`UFA_PIN_ERASE];
    assign jtagRdTake = idle & jtagRead;

    // ---- address and data shift registers
    logic [AW-1:0] addrReg;
    logic [DW-1:0] dataReg;
    logic [AW-1:0] fetchAddr;
    logic fifoInReady;
    logic fifoOutValid;
    logic [DW-1:0] fifoOutData;
    logic [DW-1:0] flash [`UFA_WORDS];
    logic [DW-1:0] loadWord;
    logic [DW-1:0] next_dataReg;

    assign loadWord = fifoOutValid ? fifoOutData : flash[addrReg];
    assign next_dataReg = dataLoad ? loadWord :
                          dataShift ? {dataReg[DW-2:0], pinLevel[`UFA_PIN_DIN]} : dataReg;
    assign dataSerialOut = dataReg[DW-1];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addrReg <= `UFA_ADDR_RESET;
            dataReg <= `UFA_DATA_RESET;
        end else begin
            if (addrShift) addrReg <= {addrReg[AW-2:0], pinLevel[`UFA_PIN_AIN]};
            else if (addrStep) addrReg <= addrReg + 1'b1;
            dataReg <= next_dataReg;
        end
    end

    // stream read: each step queues the word at the old address; a full buffer
    // holds the fetch pending and further steps are dropped until it drains
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fetchPending <= 1'b0;
            fetchAddr <= `UFA_ADDR_RESET;
        end else if (addrStep) begin
            fetchPending <= 1'b1;
            fetchAddr <= addrReg;
        end else if (fifoInReady) begin
            fetchPending <= 1'b0;
        end
    end

    ufa_fifo #(
        .WIDTH(DW),
        .DEPTH(FIFO_DEPTH)
    ) u_readahead (
        .sys_clk(sys_clk),
        .rst(rst),
        .inValid(fetchPending),
        .inReady(fifoInReady),
        .inData(flash[fetchAddr]),
        .outValid(fifoOutValid),
        .outReady(dataLoad),
        .outData(fifoOutData)
    );

    // ---- program / erase sequencer
    logic [CW-1:0] opTicks;
    logic [AW-1:0] opAddr;
    logic [DW-1:0] opData;
    logic opLast;
    logic progCommit;
    logic eraseCommit;

    assign opLast = oscTick && (state == UFA_PROG ? opTicks == CW'(PROG_TICKS - 1)
                                                  : opTicks == CW'(ERASE_TICKS - 1));
    assign progCommit = state == UFA_PROG && opLast;
    assign eraseCommit = state == UFA_ERASE && opLast;

    always_comb begin
        case (state)
            UFA_IDLE: next_state = progStart ? UFA_PROG : eraseStart ? UFA_ERASE : UFA_IDLE;
            UFA_PROG: next_state = opLast ? UFA_IDLE : UFA_PROG;
            UFA_ERASE: next_state = opLast ? UFA_IDLE : UFA_ERASE;
            default: next_state = UFA_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= UFA_IDLE;
            busy <= 1'b0;
            opTicks <= '0;
            opAddr <= `UFA_ADDR_RESET;
            opData <= `UFA_DATA_RESET;
        end else begin
            state <= next_state;
            busy <= next_state != UFA_IDLE;
            if (idle) opTicks <= '0;
            else if (oscTick) opTicks <= opTicks + 1'b1;
            if (progStart) begin
                opAddr <= pinProg ? addrReg : jtagAddr;
                opData <= pinProg ? dataReg : jtagWrData;
            end else if (eraseStart) begin
                opAddr <= addrReg;
            end
        end
    end

    // array: programming can only clear bits, erase restores one sector to ones;
    // the image comes up erased because nonvolatile content is not modelled
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `UFA_WORDS; i++) flash[i] <= `UFA_ERASED;
        end else if (eraseCommit) begin
            for (int i = 0; i < `UFA_WORDS; i++) begin
                if (sectorOf(AW'(i)) == sectorOf(opAddr)) flash[i] <= `UFA_ERASED;
            end
        end else if (progCommit) begin
            flash[opAddr] <= flash[opAddr] & opData;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            jtagRdData <= `UFA_DATA_RESET;
            jtagRdValid <= 1'b0;
        end else begin
            jtagRdValid <= jtagRdTake;
            if (jtagRdTake) jtagRdData <= flash[jtagAddr];
        end
    end

    // ---- checks
    // run length of the exported level, taken from the output itself, not the divider
    logic [7:0] oscRunLen;
    logic oscOutPrev;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            oscRunLen <= 8'h00;
            oscOutPrev <= 1'b0;
        end else begin
            oscOutPrev <= internalOscOut;
            oscRunLen <= (internalOscOut != oscOutPrev) ? 8'h01 : oscRunLen + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_busy_follows_start: assert property ((progStart || eraseStart) |=> busy [*2])
        else $error("busy did not rise after an operation start");
    a_busy_blocks_start: assert property (busy |-> (!progStart && !eraseStart
        && !dataLoad) ##1 ($stable(addrReg) && $stable(dataReg) && !jtagRdValid))
        else $error("request taken while busy");
    a_addr_step_inc: assert property (addrStep |=> addrReg == $past(addrReg) + 9'h001)
        else $error("address did not step by one");
    a_addr_shift_msb: assert property (addrShift |=> addrReg[0] == $past(pinLevel[2])
        && addrReg[8:1] == $past(addrReg[7:0]))
        else $error("address shift wrong");
    a_sector_isolated: assert property (eraseCommit && !opAddr[8] |=>
        flash[9'h100] == $past(flash[9'h100]) && flash[9'h0ff] == 16'hffff)
        else $error("erase touched the wrong sector");
    a_prog_clears_bits: assert property (progCommit |=>
        flash[$past(opAddr)] == ($past(flash[opAddr]) & $past(opData)))
        else $error("program result wrong");
    a_single_read: assert property (dataLoad && !fifoOutValid |=>
        dataReg == $past(flash[addrReg]))
        else $error("single read loaded wrong word");
    a_jtag_read: assert property (jtagRdTake |=> jtagRdValid && jtagRdData == $past(flash[jtagAddr]))
        else $error("test port read wrong");
    a_osc_half: assert property ($changed(internalOscOut) |-> oscRunLen == 8'(OSC_HALF))
        else $error("exported oscillator period wrong");
    a_prog_length: assert property ($rose(busy) && state == UFA_PROG |->
        busy [*8])
        else $error("program ended too early");

    c_program: cover property (progCommit);
    c_erase_high: cover property (eraseCommit && opAddr[8]);
    c_stream_pop: cover property (dataLoad && fifoOutValid);
    c_fifo_full: cover property (fetchPending && !fifoInReady);

endmodule : ufa_flash_access

/* File: tb/ufa_user_logic.sv */
`timescale 1ns/1ps
module ufa_user_logic (
    input wire logic sys_clk,
    input wire logic busy,
    input wire logic dataSerialOut,
    output logic addrShiftSelect,
    output logic addrShiftClock,
    output logic addrSerialIn,
    output logic dataShiftSelect,
    output logic dataShiftClock,
    output logic dataSerialIn,
    output logic programReq,
    output logic eraseReq
);
    initial begin
        {addrShiftSelect, addrShiftClock, addrSerialIn, dataShiftSelect} = 4'h0;
        {dataShiftClock, dataSerialIn, programReq, eraseReq} = 4'h0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    // six cycles per phase clears the 3-flop pin sync with room for setup and hold
    task automatic clk_addr(input logic sel, input logic b);
        addrShiftSelect <= sel;
        addrSerialIn <= b;
        idle(6);
        addrShiftClock <= 1'b1;
        idle(6);
        addrShiftClock <= 1'b0;
        addrSerialIn <= ~b; // hold is over, so the line stops carrying the bit
        idle(6);
    endtask : clk_addr

    task automatic clk_data(input logic sel, input logic b);
        dataShiftSelect <= sel;
        dataSerialIn <= b;
        idle(6);
        dataShiftClock <= 1'b1;
        idle(6);
        dataShiftClock <= 1'b0;
        dataSerialIn <= ~b;
        idle(6);
    endtask : clk_data

    task automatic shift_addr(input logic [8:0] a);
        for (int i = 8; i >= 0; i--) begin
            clk_addr(1'b1, a[i]);
        end
    endtask : shift_addr

    // reads the word out while a new one goes in behind it
    task automatic xfer(input logic [15:0] wr, output logic [15:0] rd);
        for (int i = 15; i >= 0; i--) begin
            rd[i] = dataSerialOut;
            clk_data(1'b1, wr[i]);
        end
    endtask : xfer

    task automatic req(input logic isErase, output logic seen);
        int n;
        programReq <= !isErase;
        eraseReq <= isErase;
        for (n = 0; n < 100 && busy !== 1'b1; n++) @(posedge sys_clk);
        seen = (busy === 1'b1);
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge sys_clk);
        programReq <= 1'b0;
        eraseReq <= 1'b0;
        idle(6);
    endtask : req
endmodule : ufa_user_logic

/* File: tb/test_user_flash_serial_access.sv */
`timescale 1ns/1ps
`include "ufa_defs.svh"
module test_user_flash_serial_access;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic addrShiftSelect, addrShiftClock, addrSerialIn, dataShiftSelect;
    logic dataShiftClock, dataSerialIn, programReq, eraseReq;
    logic jtagWrite = 1'b0;
    logic jtagRead = 1'b0;
    logic [8:0] jtagAddr = 9'h000;
    logic [15:0] jtagWrData = 16'h0000;
    logic [15:0] jtagRdData;
    logic jtagRdValid, dataSerialOut, busy, internalOscOut;
    logic [15:0] mem [0:511];
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    integer seed = 32'hf427;

    always #5 sys_clk = ~sys_clk;

    ufa_flash_access #(.PROG_TICKS(3), .ERASE_TICKS(4), .FIFO_DEPTH(4)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .addrShiftSelect(addrShiftSelect),
        .addrShiftClock(addrShiftClock), .addrSerialIn(addrSerialIn),
        .dataShiftSelect(dataShiftSelect), .dataShiftClock(dataShiftClock),
        .dataSerialIn(dataSerialIn), .programReq(programReq), .eraseReq(eraseReq),
        .jtagWrite(jtagWrite), .jtagRead(jtagRead), .jtagAddr(jtagAddr),
        .jtagWrData(jtagWrData), .jtagRdData(jtagRdData), .jtagRdValid(jtagRdValid),
        .dataSerialOut(dataSerialOut), .busy(busy), .internalOscOut(internalOscOut));

    ufa_user_logic i_user (
        .sys_clk(sys_clk), .busy(busy), .dataSerialOut(dataSerialOut),
        .addrShiftSelect(addrShiftSelect), .addrShiftClock(addrShiftClock),
        .addrSerialIn(addrSerialIn), .dataShiftSelect(dataShiftSelect),
        .dataShiftClock(dataShiftClock), .dataSerialIn(dataSerialIn),
        .programReq(programReq), .eraseReq(eraseReq));

    function automatic logic [15:0] rnd16();
        return 16'($random(seed));
    endfunction : rnd16

    // programming can only clear bits of an erased word
    function automatic logic [15:0] after_prog(input logic [15:0] old, input logic [15:0] d);
        return old & d;
    endfunction : after_prog

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic jtag_read(input logic [8:0] a, input logic wantValid);
        @(posedge sys_clk);
        jtagRead <= 1'b1;
        jtagAddr <= a;
        @(posedge sys_clk);
        jtagRead <= 1'b0;
        #1;
        check(16'(jtagRdValid), 16'(wantValid), "read strobe");
        if (wantValid) check(jtagRdData, mem[a], "read word");
    endtask : jtag_read

    task automatic jtag_write(input logic [8:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        jtagWrite <= 1'b1;
        jtagAddr <= a;
        jtagWrData <= d;
        @(posedge sys_clk);
        jtagWrite <= 1'b0;
    endtask : jtag_write

    task automatic wait_idle();
        repeat (3) @(posedge sys_clk);
        for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge sys_clk);
        check(16'(busy), 16'h0000, "busy stuck");
    endtask : wait_idle

    task automatic pin_op(input logic isErase);
        logic seen;
        i_user.req(isErase, seen);
        check(16'(seen), 16'h0001, "busy never rose");
        check(16'(busy), 16'h0000, "busy stuck");
    endtask : pin_op

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            $display("unexpected at %0t: run too long", $time);
            give_verdict();
        end
    end

    initial begin
        logic [8:0] a0, a1, b;
        logic [15:0] d, r;
        logic p;
        int edges;
        for (int i = 0; i < 512; i++) mem[i] = `UFA_ERASED;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(16'(busy), 16'h0000, "busy after reset");
        jtag_read(9'h1ff, 1'b1);
        d = rnd16();
        a0 = {2'b00, d[6:0]};
        a1 = a0 ^ 9'h040;
        b = 9'h0fe;
        // pin program then read back both ways
        d = rnd16();
        i_user.shift_addr(a0);
        i_user.xfer(d, r);
        pin_op(1'b0);
        mem[a0] = after_prog(mem[a0], d);
        jtag_read(a0, 1'b1);
        i_user.shift_addr(a0);
        i_user.clk_data(1'b0, 1'b0);
        i_user.xfer(rnd16(), r);
        check(r, mem[a0], "single read");
        // stream across the sector boundary, overfilling the read buffer
        for (int i = 0; i < 5; i++) begin
            d = rnd16();
            jtag_write(b + 9'(i), d);
            mem[b + 9'(i)] = after_prog(mem[b + 9'(i)], d);
            wait_idle();
        end
        i_user.shift_addr(b);
        repeat (5) i_user.clk_addr(1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            i_user.clk_data(1'b0, 1'b0);
            i_user.xfer(16'h0000, r);
            check(r, mem[b + 9'(i)], "stream word");
        end
        // requests made while busy must leave no trace
        d = rnd16();
        i_user.shift_addr(a1);
        i_user.xfer(d, r);
        fork
            pin_op(1'b0);
            begin
                for (int n = 0; n < 50 && busy !== 1'b1; n++) @(posedge sys_clk);
                jtag_read(9'h100, 1'b0);
                jtag_write(9'h100, 16'h0000);
            end
        join
        mem[a1] = after_prog(mem[a1], d);
        jtag_read(a1, 1'b1);
        jtag_read(9'h100, 1'b1);
        // sector erases, one at a time
        i_user.shift_addr(9'h05a);
        pin_op(1'b1);
        for (int i = 0; i < 256; i++) mem[i] = `UFA_ERASED;
        jtag_read(a0, 1'b1);
        jtag_read(a1, 1'b1);
        for (int i = 0; i < 4; i++) jtag_read(b + 9'(i), 1'b1);
        i_user.shift_addr(9'h1a5);
        pin_op(1'b1);
        for (int i = 256; i < 512; i++) mem[i] = `UFA_ERASED;
        jtag_read(9'h100, 1'b1);
        jtag_read(9'h101, 1'b1);
        d = rnd16();
        jtag_write(a0, d);
        mem[a0] = after_prog(mem[a0], d);
        wait_idle();
        jtag_read(a0, 1'b1);
        // a 24-cycle period gives 20 transitions in 240 cycles
        p = internalOscOut;
        edges = 0;
        repeat (240) begin
            @(posedge sys_clk);
            #1;
            if (internalOscOut !== p) edges++;
            p = internalOscOut;
        end
        check(16'(edges), 16'h0014, "oscillator transitions");
        give_verdict();
    end
endmodule : test_user_flash_serial_access
